// >>> ccs_pkg.sv
// package: register map, field layout and mode codes of the capture/shutdown unit
`default_nettype none
package ccs_pkg;
   // register byte addresses
   localparam logic [7:0] ADDR_MODE     = 8'h00;
   localparam logic [7:0] ADDR_SHDN     = 8'h04;
   localparam logic [7:0] ADDR_CAPTURE  = 8'h08;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h0c;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
   localparam logic [7:0] ADDR_OUTS     = 8'h14;
   // shutdown control field positions
   localparam int SHDN_FLAG_BIT = 7;
   localparam int SRC_LSB       = 4;
   localparam int PSA_LSB       = 2;
   localparam int PSB_LSB       = 0;
   // reset values
   localparam logic [7:0] SHDN_RESET = 8'h00;
   localparam logic [3:0] MODE_RESET = 4'h0;
   // mode codes
   localparam logic [3:0] MODE_OFF    = 4'h0;
   localparam logic [3:0] MODE_CAP_F  = 4'h4;
   localparam logic [3:0] MODE_CAP_R1 = 4'h5;
   localparam logic [3:0] MODE_CAP_R4 = 4'h6;
   localparam logic [3:0] MODE_CAP_R16 = 4'h7;
   // shutdown source codes
   localparam logic [2:0] SRC_NONE = 3'h0;
   localparam logic [2:0] SRC_CMP  = 3'h1;
   localparam logic [2:0] SRC_FLT  = 3'h4;
   localparam logic [2:0] SRC_EITHER = 3'h5;
   localparam logic [2:0] SRC_EITHER2 = 3'h7;
   // interrupt status bits
   localparam int IRQ_CAPTURE = 0;
   localparam int IRQ_SHDN    = 1;
   // axi responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// >>> ccs_edge_div.sv
// edge prescaler: pulses on the selected edge, every n-th rising edge
`default_nettype none
module ccs_edge_div
   import ccs_pkg::*;
(
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic       clear,
   input  wire logic [3:0] mode,
   input  wire logic       pin,
   output logic            fire
);
   logic       pin_q;
   logic [3:0] cnt;
   logic [3:0] next_cnt;
   logic       next_fire;
   logic       rise;
   logic       fall;

   // edge detect and prescale count
   always_comb begin
      rise = pin & ~pin_q;
      fall = ~pin & pin_q;
      next_cnt = cnt;
      next_fire = 1'b0;
      if (clear) begin
         next_cnt = 4'h0;
      end else if (mode == MODE_CAP_F) begin
         next_fire = fall;
      end else if (mode == MODE_CAP_R1) begin
         next_fire = rise; // RQ2
      end else if (mode == MODE_CAP_R4 && rise) begin
         next_cnt = (cnt == 4'h3) ? 4'h0 : cnt + 4'h1;
         next_fire = (cnt == 4'h3); // RQ1
      end else if (mode == MODE_CAP_R16 && rise) begin
         next_cnt = cnt + 4'h1;
         next_fire = (cnt == 4'hf); // RQ14
      end
   end

   // register edge state
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_q <= 1'b0;
         cnt   <= 4'h0;
         fire  <= 1'b0;
      end else begin
         pin_q <= pin;
         cnt   <= next_cnt;
         fire  <= next_fire;
      end
   end
endmodule
`default_nettype wire

// >>> ccs_top.sv
// capture unit with pwm output polarity and auto-shutdown, axi4-lite slave
`default_nettype none
//
// Contract
// [RQ1] mode 0110 captures every fourth rising edge
// [RQ2] mode 0101 captures every rising edge
// [RQ3] shutdown event sets flag, outputs to shutdown
// [RQ4] flag clear means outputs drive normally
// [RQ5] source 101: fault low or comparator low
// [RQ6] source 001: comparator low only
// [RQ7] output a: 1x tri-state, 01 high
// [RQ8] output b: 01 drives high
// [RQ9] source 000 never shuts down
// [RQ10] source 100: fault pin low only
// [RQ11] source 111: fault low or comparator low
// [RQ12] field 00 drives output low
// [RQ13] modes 11xx set pwm polarities a, b
// [RQ14] mode 0000 off/reset; 0111 every sixteenth
module ccs_top
   import ccs_pkg::*;
#(
   parameter int TW = 16
)(
   input  wire logic          aclk,
   input  wire logic          aresetn,
   input  wire logic [7:0]    s_axi_awaddr,
   input  wire logic          s_axi_awvalid,
   output logic               s_axi_awready,
   input  wire logic [31:0]   s_axi_wdata,
   input  wire logic [3:0]    s_axi_wstrb,
   input  wire logic          s_axi_wvalid,
   output logic               s_axi_wready,
   output logic [1:0]         s_axi_bresp,
   output logic               s_axi_bvalid,
   input  wire logic          s_axi_bready,
   input  wire logic [7:0]    s_axi_araddr,
   input  wire logic          s_axi_arvalid,
   output logic               s_axi_arready,
   output logic [31:0]        s_axi_rdata,
   output logic [1:0]         s_axi_rresp,
   output logic               s_axi_rvalid,
   input  wire logic          s_axi_rready,
   input  wire logic [TW-1:0] timer_value,
   input  wire logic          capture_in,
   input  wire logic          pwm_raw,
   input  wire logic          fault_input_pin,
   input  wire logic          analog_comparator_out,
   output logic               modulated_output_a,
   output logic               modulated_output_a_oe,
   output logic               modulated_output_b,
   output logic               modulated_output_b_oe,
   output logic               irq
);
   logic [3:0]    unit_mode_select;
   logic [7:0]    shdn;
   logic [TW-1:0] cap_val;
   logic [1:0]    irq_stat;
   logic [1:0]    irq_mask;
   logic [3:0]    next_mode;
   logic [7:0]    next_shdn;
   logic [TW-1:0] next_cap;
   logic [1:0]    next_stat;
   logic [1:0]    next_mask;
   logic          aw_hold;
   logic          w_hold;
   logic [7:0]    aw_addr;
   logic [31:0]   w_data;
   logic [3:0]    w_strb;
   logic          next_aw_hold;
   logic          next_w_hold;
   logic [7:0]    next_aw_addr;
   logic [31:0]   next_w_data;
   logic [3:0]    next_w_strb;
   logic          next_bvalid;
   logic          next_rvalid;
   logic [1:0]    next_bresp;
   logic [1:0]    next_rresp;
   logic [31:0]   next_rdata;
   logic          next_awready;
   logic          next_wready;
   logic          next_arready;
   logic          wr_go;
   logic          wr_ok;
   logic          rd_ok;
   logic [31:0]   rd_word;
   logic          cap_fire;
   logic          shdn_trig;
   logic          shutdown_event_flag;
   logic [2:0]    shutdown_source_select;
   logic [1:0]    pin_a_shutdown_state;
   logic [1:0]    pin_b_shutdown_state;
   logic          next_oa;
   logic          next_oa_oe;
   logic          next_ob;
   logic          next_ob_oe;
   logic          next_irq;
   logic          pol_a;
   logic          pol_b;
   logic          pwm_mode;

   assign shutdown_event_flag    = shdn[SHDN_FLAG_BIT];
   assign shutdown_source_select = shdn[SRC_LSB +: 3];
   assign pin_a_shutdown_state   = shdn[PSA_LSB +: 2];
   assign pin_b_shutdown_state   = shdn[PSB_LSB +: 2];

   // capture edge prescaler
   ccs_edge_div u_div (
      .aclk    (aclk),
      .aresetn (aresetn),
      .clear   (unit_mode_select == MODE_OFF), // RQ14
      .mode    (unit_mode_select),
      .pin     (capture_in),
      .fire    (cap_fire)
   );

   // shutdown source selection
   always_comb begin
      unique case (shutdown_source_select)
         SRC_NONE:    shdn_trig = 1'b0; // RQ9
         SRC_CMP:     shdn_trig = ~analog_comparator_out; // RQ6
         SRC_FLT:     shdn_trig = ~fault_input_pin; // RQ10
         SRC_EITHER:  shdn_trig = ~fault_input_pin
                                  | ~analog_comparator_out; // RQ5
         SRC_EITHER2: shdn_trig = ~fault_input_pin
                                  | ~analog_comparator_out; // RQ11
         // reserved source codes never shut the outputs down
         default:     shdn_trig = 1'b0;
      endcase
   end

   // axi write channel capture and read decode
   always_comb begin
      next_aw_hold = aw_hold;
      next_aw_addr = aw_addr;
      next_w_hold  = w_hold;
      next_w_data  = w_data;
      next_w_strb  = w_strb;
      // address and data halves may arrive in either order
      if (s_axi_awvalid && s_axi_awready) begin
         next_aw_hold = 1'b1;
         next_aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_w_hold = 1'b1;
         next_w_data = s_axi_wdata;
         next_w_strb = s_axi_wstrb;
      end
      // a write commits only once both halves are held
      wr_go = aw_hold && w_hold && !s_axi_bvalid;
      if (wr_go) begin
         next_aw_hold = 1'b0;
         next_w_hold  = 1'b0;
      end
      // readies stay low until the response has been taken
      next_awready = !next_aw_hold && !(wr_go || s_axi_bvalid);
      next_wready  = !next_w_hold && !(wr_go || s_axi_bvalid);
      // unmapped or read-only targets answer with an error, no effect
      wr_ok = (aw_addr == ADDR_MODE) || (aw_addr == ADDR_SHDN)
              || (aw_addr == ADDR_IRQ_STAT) || (aw_addr == ADDR_IRQ_MASK);
      next_bvalid = s_axi_bvalid;
      next_bresp  = s_axi_bresp;
      if (s_axi_bvalid && s_axi_bready) begin
         next_bvalid = 1'b0;
      end
      if (wr_go) begin
         next_bvalid = 1'b1;
         next_bresp  = wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      // read data is registered on the same edge that takes the address
      rd_ok = 1'b1;
      unique case (s_axi_araddr)
         ADDR_MODE:     rd_word = {28'h0, unit_mode_select};
         ADDR_SHDN:     rd_word = {24'h0, shdn};
         ADDR_CAPTURE:  rd_word = 32'(cap_val);
         ADDR_IRQ_STAT: rd_word = {30'h0, irq_stat};
         ADDR_IRQ_MASK: rd_word = {30'h0, irq_mask};
         ADDR_OUTS:     rd_word = {28'h0, modulated_output_b_oe,
                           modulated_output_b, modulated_output_a_oe,
                           modulated_output_a};
         default: begin
            rd_word = 32'h0;
            rd_ok   = 1'b0;
         end
      endcase
      next_rvalid  = s_axi_rvalid;
      next_rdata   = s_axi_rdata;
      next_rresp   = s_axi_rresp;
      if (s_axi_rvalid && s_axi_rready) begin
         next_rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         next_rvalid = 1'b1;
         next_rdata  = rd_word;
         next_rresp  = rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
      // one read at a time: refuse addresses while data is pending
      next_arready = !next_rvalid && !(s_axi_arvalid && s_axi_arready);
   end

   // register file next state
   always_comb begin
      next_mode = unit_mode_select;
      next_shdn = shdn;
      next_mask = irq_mask;
      next_stat = irq_stat;
      next_cap  = cap_val;
      // writes with the low byte lane off are dropped
      if (wr_go && w_strb[0]) begin
         unique case (aw_addr)
            ADDR_MODE:     next_mode = w_data[3:0];
            ADDR_SHDN:     next_shdn = w_data[7:0];
            ADDR_IRQ_STAT: next_stat = irq_stat & ~w_data[1:0];
            ADDR_IRQ_MASK: next_mask = w_data[1:0];
            default:       next_mode = unit_mode_select;
         endcase
      end
      // off mode holds the captured value at zero; it wins over capture events
      if (unit_mode_select == MODE_OFF) begin
         next_cap = '0; // RQ14
      end else if (cap_fire) begin
         next_cap = timer_value; // RQ1
         next_stat[IRQ_CAPTURE] = 1'b1;
      end
      // hardware set wins over a software clear of the flag
      if (shdn_trig) begin
         next_shdn[SHDN_FLAG_BIT] = 1'b1; // RQ3
         next_stat[IRQ_SHDN] = 1'b1;
      end
   end

   // pin drive: normal pwm or shutdown state
   always_comb begin
      pwm_mode = unit_mode_select[3:2] == 2'h3;
      pol_a = unit_mode_select[1]; // RQ13
      pol_b = unit_mode_select[0]; // RQ13
      // outside the pwm modes both pins are low and released while the shutdown flag is clear
      next_oa    = pwm_mode & (pwm_raw ^ pol_a);
      next_ob    = pwm_mode & (pwm_raw ^ pol_b);
      next_oa_oe = pwm_mode;
      next_ob_oe = pwm_mode;
      // shutdown state holds until software clears the flag
      if (shutdown_event_flag) begin // RQ4
         next_oa_oe = ~pin_a_shutdown_state[1]; // RQ7
         next_oa    = ~pin_a_shutdown_state[1]
                      & pin_a_shutdown_state[0]; // RQ12
         next_ob_oe = ~pin_b_shutdown_state[1];
         next_ob    = ~pin_b_shutdown_state[1]
                      & pin_b_shutdown_state[0]; // RQ8
      end
      // irq follows status and mask in the same cycle as the status
      next_irq = |(next_stat & next_mask);
   end

   // state registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         unit_mode_select      <= MODE_RESET;
         shdn                  <= SHDN_RESET;
         cap_val               <= '0;
         irq_stat              <= 2'h0;
         irq_mask              <= 2'h0;
         aw_hold               <= 1'b0;
         w_hold                <= 1'b0;
         aw_addr               <= 8'h00;
         w_data                <= 32'h0;
         w_strb                <= 4'h0;
         s_axi_awready         <= 1'b0;
         s_axi_wready          <= 1'b0;
         s_axi_arready         <= 1'b0;
         s_axi_bvalid          <= 1'b0;
         s_axi_bresp           <= RESP_OKAY;
         s_axi_rvalid          <= 1'b0;
         s_axi_rdata           <= 32'h0;
         s_axi_rresp           <= RESP_OKAY;
         modulated_output_a    <= 1'b0;
         modulated_output_a_oe <= 1'b0;
         modulated_output_b    <= 1'b0;
         modulated_output_b_oe <= 1'b0;
         irq                   <= 1'b0;
      end else begin
         unit_mode_select      <= next_mode;
         shdn                  <= next_shdn;
         cap_val               <= next_cap;
         irq_stat              <= next_stat;
         irq_mask              <= next_mask;
         aw_hold               <= next_aw_hold;
         w_hold                <= next_w_hold;
         aw_addr               <= next_aw_addr;
         w_data                <= next_w_data;
         w_strb                <= next_w_strb;
         s_axi_awready         <= next_awready;
         s_axi_wready          <= next_wready;
         s_axi_arready         <= next_arready;
         s_axi_bvalid          <= next_bvalid;
         s_axi_bresp           <= next_bresp;
         s_axi_rvalid          <= next_rvalid;
         s_axi_rdata           <= next_rdata;
         s_axi_rresp           <= next_rresp;
         modulated_output_a    <= next_oa;
         modulated_output_a_oe <= next_oa_oe;
         modulated_output_b    <= next_ob;
         modulated_output_b_oe <= next_ob_oe;
         irq                   <= next_irq;
      end
   end
endmodule
`default_nettype wire

// >>> ccs_top_properties.sv
// assertion checker for the capture/shutdown unit
`default_nettype none
module ccs_top_props
   import ccs_pkg::*;
#(
   parameter int TW = 16
)(
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic [7:0]  s_axi_awaddr,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0]  s_axi_wstrb,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        fault_input_pin,
   input wire logic        analog_comparator_out,
   input wire logic        modulated_output_a,
   input wire logic        modulated_output_a_oe,
   input wire logic        modulated_output_b,
   input wire logic        modulated_output_b_oe
);
   logic       pend;
   logic [7:0] wa;
   logic [6:0] wd;
   logic [6:0] sh;
   logic       trig;
   // shadow of source and pin fields, committed one edge after the write
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pend <= 1'b0;
         sh   <= 7'h00;
      end else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid
                   && s_axi_wready) begin
         pend <= s_axi_wstrb[0];
         wa   <= s_axi_awaddr;
         wd   <= s_axi_wdata[6:0];
      end else begin
         pend <= 1'b0;
         if (pend && wa == ADDR_SHDN) sh <= wd;
      end
   end
   // shutdown trigger from the shadowed source code
   always_comb begin
      case (sh[6:4])
         SRC_CMP:                 trig = !analog_comparator_out;
         SRC_FLT:                 trig = !fault_input_pin;
         SRC_EITHER, SRC_EITHER2: trig = !fault_input_pin
                                     || !analog_comparator_out;
         default:                 trig = 1'b0;
      endcase
   end
   sequence wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence a_safe;
      sh[3] ? !modulated_output_a_oe
            : modulated_output_a_oe && modulated_output_a == sh[2];
   endsequence
   sequence b_safe;
      sh[1] ? !modulated_output_b_oe
            : modulated_output_b_oe && modulated_output_b == sh[0];
   endsequence
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   chk_shdn_pin_a:
      assert property (trig |-> ##2 a_safe) else $error("pin a state");
   chk_shdn_pin_b:
      assert property (trig |-> ##2 b_safe) else $error("pin b state");
   chk_write_resp:
      assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
      else $error("write response late");
   chk_read_resp:
      assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2]
         s_axi_rvalid) else $error("read data late");
   chk_bresp_hold:
      assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
         && $stable(s_axi_bresp)) else $error("bresp dropped");
   chk_rdata_hold:
      assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
         && $stable(s_axi_rdata)) else $error("rdata dropped");
   chk_write_refused:
      assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while responding");
   chk_read_refused:
      assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while responding");
endmodule
bind ccs_top ccs_top_props #(.TW(TW)) u_props (.aclk, .aresetn,
   .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
   .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
   .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .fault_input_pin,
   .analog_comparator_out, .modulated_output_a, .modulated_output_a_oe,
   .modulated_output_b, .modulated_output_b_oe);
`default_nettype wire

// >>> ccs_pins_model.sv
// pin-side model: fault and comparator sources, pads of both outputs
`default_nettype none
module ccs_pins_model (
   input  wire logic aclk,
   input  wire logic flt_low,
   input  wire logic cmp_low,
   input  wire logic a,
   input  wire logic a_oe,
   input  wire logic b,
   input  wire logic b_oe,
   output logic      fault_input_pin,
   output logic      analog_comparator_out,
   output logic      pad_a,
   output logic      pad_b
);
   timeunit 1ns;
   timeprecision 1ps;
   logic t = 1'b0;
   // changing pattern seen on a pad that nobody drives
   always @(posedge aclk) t <= !t;
   // sources idle high and pull low while a fault is commanded
   assign fault_input_pin       = !flt_low;
   assign analog_comparator_out = !cmp_low;
   assign pad_a = a_oe ? a : t;
   assign pad_b = b_oe ? b : t;
endmodule
`default_nettype wire

// >>> testbench.sv
// self-checking bench for the capture/shutdown unit
`default_nettype none
module testbench import ccs_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic        aclk = 0, aresetn = 0, s_axi_bready = 0, s_axi_rready = 0;
   logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic        s_axi_arready, s_axi_rvalid, irq, pad_a, pad_b;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rs, f, e, m;
   logic [15:0] timer_value = 0;
   logic        capture_in = 0, pwm_raw = 0, flt_low = 0, cmp_low = 0;
   logic        fault_input_pin, analog_comparator_out, shut;
   logic        modulated_output_a, modulated_output_a_oe;
   logic        modulated_output_b, modulated_output_b_oe;
   logic [2:0]  srcs [5] = '{SRC_NONE, SRC_CMP, SRC_FLT, SRC_EITHER,
                             SRC_EITHER2};
   int          mismatches = 0, n_compared = 0;
   // 50 MHz clock
   always #10 aclk = !aclk;
   ccs_top #(.TW(16)) uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .timer_value,
      .capture_in, .pwm_raw, .fault_input_pin, .analog_comparator_out,
      .modulated_output_a, .modulated_output_a_oe, .modulated_output_b,
      .modulated_output_b_oe, .irq);
   ccs_pins_model pins (.aclk, .flt_low, .cmp_low, .a(modulated_output_a),
      .a_oe(modulated_output_a_oe), .b(modulated_output_b),
      .b_oe(modulated_output_b_oe), .fault_input_pin,
      .analog_comparator_out, .pad_a, .pad_b);
   task automatic print_verdict();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic hung();
      chk("handshake", 1, 0);
      print_verdict();
   endtask
   task automatic tick(int n);
      repeat (n) @(posedge aclk);
   endtask
   task automatic wr(logic [7:0] a, logic [31:0] d);
      int n = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
      end while (s_axi_bvalid !== 1'b1 && n < 60);
      rs = s_axi_bresp;
      if (n >= 60) hung();
   endtask
   task automatic rdr(logic [7:0] a);
      int n = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_arready) s_axi_arvalid <= 0;
      end while (s_axi_rvalid !== 1'b1 && n < 60);
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      if (n >= 60) hung();
   endtask
   task automatic t_regs();
      rdr(ADDR_SHDN);
      chk("shdn reset", 32'(SHDN_RESET), rd);
      rdr(8'h18);
      chk("unmapped rresp", 32'(RESP_SLVERR), 32'(rs));
      chk("unmapped rdata", 0, rd);
      wr(8'h18, 32'h5a);
      chk("unmapped bresp", 32'(RESP_SLVERR), 32'(rs));
   endtask
   task automatic t_cap(logic [3:0] md, int n);
      wr(ADDR_MODE, 32'(MODE_OFF));
      rdr(ADDR_CAPTURE);
      chk("off clears", 0, rd);
      wr(ADDR_MODE, 32'(md));
      wr(ADDR_IRQ_STAT, 32'h3);
      for (int i = 1; i <= n; i++) begin
         timer_value <= 16'h0a00 + 16'(i);
         capture_in <= 1;
         tick(4);
         capture_in <= 0;
         tick(4);
         if (i == n - 1) begin
            rdr(ADDR_IRQ_STAT);
            chk("early capture", 0, rd & 1);
         end
      end
      rdr(ADDR_CAPTURE);
      chk("captured", 32'h0a00 + n, rd);
   endtask
   task automatic t_irq();
      wr(ADDR_IRQ_MASK, 32'h1);
      tick(2);
      chk("irq raised", 1, 32'(irq));
      wr(ADDR_IRQ_MASK, 32'h0);
      tick(2);
      chk("irq masked", 0, 32'(irq));
      wr(ADDR_IRQ_MASK, 32'h1);
      wr(ADDR_IRQ_STAT, 32'h1);
      tick(2);
      chk("irq cleared", 0, 32'(irq));
   endtask
   task automatic t_shdn();
      wr(ADDR_MODE, 32'(MODE_CAP_R1));
      for (int s = 0; s < 5; s++) begin
         for (int c = 0; c < 2; c++) begin
            f = 2'(s + c);
            shut = srcs[s] == SRC_CMP ? c == 1 : srcs[s] == SRC_FLT ?
                   c == 0 : srcs[s] != SRC_NONE;
            e = shut && !f[1] ? {1'b1, f[0]} : 2'b00;
            m = shut && f[1] ? 2'b10 : 2'b11;
            wr(ADDR_SHDN, 32'({1'b0, srcs[s], f, f}));
            flt_low <= c == 0;
            cmp_low <= c == 1;
            tick(4);
            rdr(ADDR_SHDN);
            chk("flag", 32'(shut), 32'(rd[7]));
            rdr(ADDR_OUTS);
            chk("pins", 32'({e, e}), rd & {m, m});
            flt_low <= 0;
            cmp_low <= 0;
            tick(2);
            wr(ADDR_SHDN, 32'({1'b0, srcs[s], f, f}));
            tick(3);
            rdr(ADDR_OUTS);
            chk("pins released", 0, rd);
         end
      end
   endtask
   task automatic t_pwm();
      wr(ADDR_SHDN, 32'h0);
      for (int md = 12; md < 16; md++) begin
         wr(ADDR_MODE, 32'(md));
         for (int r = 0; r < 2; r++) begin
            pwm_raw <= r[0];
            tick(3);
            chk("pwm a", 32'(r[0] ^ md[1]), 32'(pad_a));
            chk("pwm b", 32'(r[0] ^ md[0]), 32'(pad_b));
         end
      end
   endtask
   // main sequence
   initial begin
      tick(16);
      aresetn <= 1;
      tick(2);
      t_regs();
      t_cap(MODE_CAP_R1, 1);
      t_cap(MODE_CAP_R4, 4);
      t_cap(MODE_CAP_R16, 16);
      t_cap(MODE_CAP_F, 1);
      t_irq();
      t_shdn();
      t_pwm();
      print_verdict();
   end
endmodule
`default_nettype wire
